// ==== bench/ptp_host.sv ====
// Purpose: Host controller model on the serial link
// Assumes: 8N1 or 8E1 framing, DIV clocks per bit, idle line high
// Notes:   Received reply bytes queue up in rx_q for the bench
`timescale 1ns/1ps
module ptp_host #(
   parameter int DIV = 16
) (
   input  wire logic pclk,
   input  wire logic txd,
   output logic      rxd
);
   logic [7:0] rx_q[$];
   logic       even_par = 1'b0; // Set by the bench for 8E1 frames
   // ==========================================================
   // Sender, LSB first, caller enters just after a clock edge
   initial rxd = 1'b1;
   task automatic send_byte(input logic [7:0] b);
      logic [10:0] f;
      f = {1'b1, even_par ? ^b : 1'b1, b, 1'b0};
      for (int i = 0; i < (even_par ? 11 : 10); i++) begin
         rxd <= f[i];
         repeat (DIV) @(posedge pclk);
      end
   endtask
   // Control byte, command, column xor; bad flips checksum bits
   task automatic send_req(input logic [7:0] c, input logic [7:0] bad);
      send_byte(8'hC0);
      send_byte(c);
      send_byte(8'hC0 ^ c ^ bad);
   endtask
   // ==========================================================
   // Receiver; a bad stop bit drops the byte so stray edges show up
   initial begin
      logic [7:0] b;
      forever begin
         @(negedge txd);
         repeat (DIV / 2) @(posedge pclk);
         for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge pclk);
            b[i] = txd;
         end
         if (even_par) repeat (DIV) @(posedge pclk); // Skip parity
         repeat (DIV) @(posedge pclk);
         if (txd === 1'b1) rx_q.push_back(b);
      end
   end
endmodule

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench for the telegram handler
// Assumes: Bit divisor 16, a millisecond shortened to 50 clocks
// Notes:   cts_n raised once to hold a reply back under flow control
`timescale 1ns/1ps
module tb_top;
   logic                pclk, presetn, psel, penable, pwrite, cts_n;
   logic [7:0]          paddr;
   logic [31:0]         pwdata, prdata, r;
   logic                pready, pslverr, txd, rxd, rts_n, line_diff;
   logic                measure_on, sleep_on, e;
   int                  failures, n_checks, cyc;
   ptp_pkg::ptp_sense_t sense;
   ptp_core #(.MS_CYCLES(50)) ptp_core_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rxd(rxd), .cts_n(cts_n), .sense(sense),
      .txd(txd), .rts_n(rts_n), .line_diff(line_diff),
      .measure_on(measure_on), .sleep_on(sleep_on));
   ptp_host #(.DIV(16)) ptp_host_i (.pclk(pclk), .txd(txd), .rxd(rxd));
   // ==========================================================
   // Compare and report
   task automatic check(input logic [31:0] s, x, input string m);
      n_checks++;
      if (s !== x) begin
         failures++;
         $display("mismatch t=%0t %s seen %h exp %h", $time, m, s, x);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // One APB transfer, request held until pready is sampled
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Wait for an n-byte reply, then judge each byte and the xor
   task automatic reply(input int n, input logic [63:0] body);
      logic [7:0] x, b;
      int t;
      x = 8'h00;
      t = 0;
      while (ptp_host_i.rx_q.size() < n && t < 3000) begin
         @(posedge pclk);
         t++;
      end
      check(32'(ptp_host_i.rx_q.size()), 32'(n), "length");
      if (ptp_host_i.rx_q.size() >= n) begin
         for (int i = n - 2; i >= 0; i--) begin
            b = body[8*i +: 8];
            x ^= b;
            check(ptp_host_i.rx_q.pop_front(), b, "byte");
         end
         check(ptp_host_i.rx_q.pop_front(), x, "xor");
      end
   endtask
   // Longer than one periodic interval, so a stray telegram shows
   task automatic quiet;
      repeat (1800) @(posedge pclk);
      check(32'(ptp_host_i.rx_q.size()), 0, "silent");
   endtask
   // ==========================================================
   // Scenarios
   task automatic cfg_test;
      apb(1'b0, 8'h04, 32'h0);
      check(r, 32'h196E, "baud reset");
      apb(1'b1, 8'h04, 32'h10);
      apb(1'b0, 8'h04, 32'h0);
      check(r, 32'h10, "baud");
      apb(1'b0, 8'h00, 32'h0);
      check(r, 32'h0, "ctrl reset");
      apb(1'b0, 8'h10, 32'h0);
      check(32'(e), 32'h1, "unmapped");
      apb(1'b1, 8'h00, 32'h3);
      check({30'h0, line_diff, rts_n}, 32'h3, "diff");
      apb(1'b1, 8'h00, 32'h2);
      @(posedge pclk);
      check({30'h0, line_diff, rts_n}, 32'h0, "flow");
      cts_n <= 1'b1;
      ptp_host_i.send_req(8'hF1, 8'h00);
      quiet();
      cts_n <= 1'b0;
      reply(7, {16'hD04A, 32'h12345678});
      apb(1'b1, 8'h00, 32'h4);
      ptp_host_i.even_par = 1'b1;
      ptp_host_i.send_req(8'hF1, 8'h00);
      reply(7, {16'hD04A, 32'h12345678});
      ptp_host_i.even_par = 1'b0;
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h08, 32'h1E);
   endtask
   task automatic data_test;
      ptp_host_i.send_req(8'hF6, 8'h00);
      reply(7, {16'hD04A, 32'h0000ABCD});
      ptp_host_i.send_req(8'hF8, 8'h00);
      reply(9, {16'hD04A, 32'h12345678, 16'hABCD});
      ptp_host_i.send_req(8'hFA, 8'h00);
      reply(7, {16'hD04A, 8'h00, 24'h413031});
   endtask
   task automatic fault_test;
      for (int k = 0; k < 6; k++) begin
         if (k != 4) begin
            sense.fault_sel <= 3'(k);
            ptp_host_i.send_req(8'hFC, 8'h00);
            reply(7, {16'hD04A, 8'h00, 16'h4530,
                      8'(8'h30 + k)});
         end
      end
   endtask
   task automatic drop_test;
      ptp_host_i.send_req(8'hF1, 8'h01);
      quiet();
      ptp_host_i.send_req(8'hFB, 8'h00);
      ptp_host_i.send_req(8'hF0, 8'h00);
      quiet();
      ptp_host_i.send_byte(8'h55);
      ptp_host_i.send_req(8'hF1, 8'h00);
      reply(7, {16'hD04A, 32'h12345678});
   endtask
   task automatic measure_test;
      ptp_host_i.send_req(8'hF4, 8'h00);
      reply(7, {16'hD04A, 32'h12345678});
      check(32'(measure_on), 32'h1, "measure on");
      ptp_host_i.send_req(8'hF5, 8'h00);
      reply(7, {16'hD04A, 32'h12345678});
      check(32'(measure_on), 32'h0, "measure off");
   endtask
   task automatic cyclic_test;
      ptp_host_i.send_req(8'hF2, 8'h00);
      reply(7, {16'hD04A, 32'h12345678});
      reply(7, {16'hD04A, 32'h12345678});
      ptp_host_i.send_req(8'hF3, 8'h00);
      repeat (3000) @(posedge pclk);
      ptp_host_i.rx_q.delete();
      quiet();
   endtask
   task automatic sleep_test;
      ptp_host_i.send_req(8'hFD, 8'h00);
      quiet();
      check({sleep_on, measure_on}, 32'h2, "sleep");
   endtask
   // ==========================================================
   // Clock, watchdog and main sequence
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 90000) begin
         failures++;
         complete_run();
      end
   end
   initial begin
      {psel, penable, pwrite, cts_n, paddr, pwdata} = '0;
      presetn = 1'b0;
      sense = {4'hD, 3'b010, 4'b1010, 32'h12345678, 16'hABCD,
               24'h413031, 3'h5};
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      cfg_test();
      data_test();
      fault_test();
      drop_test();
      measure_test();
      cyclic_test();
      sleep_test();
      complete_run();
   end
endmodule

// ==== design/ptp_cfg.svh ====
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 250 MHz pclk, byte-addressed APB
// Notes:   Definitions only
`ifndef PTP_CFG_SVH
`define PTP_CFG_SVH
// ==========================================================
// Telegram constants
`define PTP_SYNC_BYTE 8'hC0
`define PTP_CMD_POS1  8'hF1
`define PTP_CMD_POSC  8'hF2
`define PTP_CMD_STOPC 8'hF3
`define PTP_CMD_MON   8'hF4
`define PTP_CMD_MOFF  8'hF5
`define PTP_CMD_SPD1  8'hF6
`define PTP_CMD_SPDC  8'hF7
`define PTP_CMD_BOTH1 8'hF8
`define PTP_CMD_BOTHC 8'hF9
`define PTP_CMD_MARK  8'hFA
`define PTP_CMD_FAULT 8'hFC
`define PTP_CMD_SLEEP 8'hFD
`define PTP_LEN_SHORT 4'h7
`define PTP_LEN_LONG  4'h9
`define PTP_CHR_E     8'h45
`define PTP_CHR_0     8'h30
// ==========================================================
// Register map and fields
`define PTP_A_CTRL    8'h00
`define PTP_A_BAUD    8'h04
`define PTP_A_CYCLE   8'h08
`define PTP_A_STAT    8'h0C
`define PTP_F_DIFF    0
`define PTP_F_FLOW    1
`define PTP_F_FMT_LO  2
`define PTP_CTRL_RST  4'h0
`define PTP_CYC_RST   5'h04
`define PTP_CYC_MIN   5'h01
`define PTP_CYC_MAX   5'h1E
`define PTP_DIV_MIN   16'h0010
// ==========================================================
// Timing
`define PTP_CLK_HZ    250000000
`define PTP_CLK_NS    4
`define PTP_BAUD_DEF  38400
`define PTP_DIV_RST   16'(`PTP_CLK_HZ / `PTP_BAUD_DEF)
`define PTP_MS_NS     1000000
`endif

// ==== design/ptp_core.sv ====
// Purpose: Request/response telegram handler on a serial link
// Assumes: Inputs synchronous to pclk; sensor data held stable
// Notes:   Config over APB; changing it mid-frame corrupts that frame
`timescale 1ns/1ps
`include "ptp_cfg.svh"
// Functional notes
// R1: Request is control, command, checksum bytes
// R2: Host sends control byte 0xC0
// R3: F1 single, F2 periodic position, F3 stop
// R4: F4 starts measuring, F5 stops it
// R5: F6 single speed, F7 periodic speed
// R6: F8 single combined, F9 periodic combined
// R7: FA marker, FC fault code, FD sleep
// R8: Checksum is XOR of first two bytes
// R9: Bad checksum: drop silently
// R10: Most replies are seven bytes
// R11: Combined replies are nine bytes
// R12: Marker/fault replies: byte two zero
// R13: Status byte zero layout, low nibble zero
// R14: Status byte one flag layout
// R15: Data value MSB first, checksum last
// R16: Marker label sent as three ASCII bytes
// R17: Fault code sent as three ASCII bytes
// R18: Periodic reply each 1..30 ms cycle
// R19: Selectable 8N1, 8E1, 8O1, 8N2 format
// R20: Baud divisor configurable, 38400 default
// R21: RTS/CTS only on single-ended, default off
// R22: Line standard selectable, same content
// R23: Speed value MSB first, then checksum
// R24: Quality field carries two-bit grade
// R25: Unknown commands ignored silently
// R26: Hunt for control byte to resync
module ptp_core #(
   parameter int unsigned MS_CYCLES = `PTP_MS_NS / `PTP_CLK_NS
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                rxd,
   input  wire logic                cts_n,
   input  wire ptp_pkg::ptp_sense_t sense,
   output logic                     txd,
   output logic                     rts_n,
   output logic                     line_diff,
   output logic                     measure_on,
   output logic                     sleep_on
);
   // ==========================================================
   // Helpers
   function automatic logic [3:0] nbits(input logic [1:0] f);
      nbits = (f == ptp_pkg::F_8N1) ? 4'hA : 4'hB;
   endfunction

   function automatic logic apb_hit(input logic [7:0] a);
      apb_hit = (a == `PTP_A_CTRL) || (a == `PTP_A_BAUD) ||
                (a == `PTP_A_CYCLE) || (a == `PTP_A_STAT);
   endfunction

   // Ninth frame bit: parity, or a stop bit for 8N1 and 8N2
   function automatic logic bit8(input logic [1:0] f,
                                 input logic [7:0] d);
      case (f)
         ptp_pkg::F_8E1: bit8 = ^d;
         ptp_pkg::F_8O1: bit8 = ~^d;
         default:        bit8 = 1'b1;
      endcase
   endfunction

   // ==========================================================
   // State
   logic [3:0]  ctrl_r;
   logic [15:0] div_r;
   logic [4:0]  cyc_r;
   logic        pready_r, pslverr_r;
   logic [31:0] prdata_r, rd_mux;
   ptp_pkg::ptp_ser_t  rx_st_r, tx_st_r;
   logic [15:0] rx_cnt_r, tx_cnt_r;
   logic [3:0]  rx_n_r, bit_n_r, left_r;
   logic [9:0]  rx_sh_r, rx_w;
   logic        rx_v_r, rx_ok;
   logic [7:0]  rx_byte_r, cmd_r, ex_cmd_r, chk_r, tx_byte;
   logic [1:0]  idx_r;
   logic        ex_v_r, measure_r, sleep_r, per_r, go_r;
   ptp_pkg::ptp_kind_t per_kind_r, go_kind_r;
   logic [31:0] ms_cnt_r;
   logic [4:0]  cyc_cnt_r;
   logic        tick_r, txd_r, rts_n_r;
   logic [71:0] msg_r;
   logic [9:0]  sh_r;

   wire [1:0] fmt = ctrl_r[`PTP_F_FMT_LO +: 2];
   wire flow_eff = ctrl_r[`PTP_F_FLOW] & ~ctrl_r[`PTP_F_DIFF]; // R21
   wire setup = psel & ~penable & ~pready_r;
   wire wr_acc = psel & penable & pready_r & pwrite;
   wire load = go_r & (tx_st_r == ptp_pkg::S_IDLE);

   // ==========================================================
   // APB slave: one-cycle access phase, error on unmapped address
   always_comb begin
      case (paddr)
         `PTP_A_CTRL:  rd_mux = {28'h0, ctrl_r};
         `PTP_A_BAUD:  rd_mux = {16'h0, div_r};
         `PTP_A_CYCLE: rd_mux = {27'h0, cyc_r};
         `PTP_A_STAT:  rd_mux = {16'h0, ex_cmd_r, 2'h0,
                                 per_kind_r, per_r, sleep_r,
                                 measure_r};
         default:      rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0;
      end else begin
         pready_r <= setup;
         if (setup) begin
            pslverr_r <= ~apb_hit(paddr);
            prdata_r  <= pwrite ? 32'h0 : rd_mux;
         end
      end
   end

   // Config writes; out-of-range divisor or cycle is clamped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= `PTP_CTRL_RST; // R19 R21 R22
         div_r  <= `PTP_DIV_RST;  // R20
         cyc_r  <= `PTP_CYC_RST;  // R18
      end else if (wr_acc) begin
         case (paddr)
            `PTP_A_CTRL: ctrl_r <= pwdata[3:0]; // R22
            `PTP_A_BAUD:
               div_r <= (pwdata[15:0] < `PTP_DIV_MIN) ?
                        `PTP_DIV_MIN : pwdata[15:0]; // R20
            `PTP_A_CYCLE:
               cyc_r <= (pwdata[4:0] < `PTP_CYC_MIN) ? `PTP_CYC_MIN :
                        (pwdata[4:0] > `PTP_CYC_MAX) ? `PTP_CYC_MAX :
                        pwdata[4:0]; // R18
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Receiver: mid-bit sampling, frames with bad parity/stop dropped
   always_comb begin
      rx_w  = (fmt == ptp_pkg::F_8N1) ? {1'b1, rx_sh_r[9:1]} : rx_sh_r;
      rx_ok = rx_w[9] & (rx_w[8] == bit8(fmt, rx_w[7:0])); // R19
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_st_r   <= ptp_pkg::S_IDLE;
         rx_cnt_r  <= 16'h0;
         rx_n_r    <= 4'h0;
         rx_sh_r   <= 10'h0;
         rx_v_r    <= 1'b0;
         rx_byte_r <= 8'h0;
      end else begin
         rx_v_r <= 1'b0;
         case (rx_st_r)
            ptp_pkg::S_IDLE: if (!rxd) begin
               rx_cnt_r <= div_r >> 1;
               rx_st_r  <= ptp_pkg::S_START;
            end
            ptp_pkg::S_START: begin
               if (rx_cnt_r != 16'h0) begin
                  rx_cnt_r <= rx_cnt_r - 16'h1;
               end else if (rxd) begin
                  rx_st_r <= ptp_pkg::S_IDLE; // Glitch, not a start
               end else begin
                  rx_cnt_r <= div_r - 16'h1;
                  rx_n_r   <= nbits(fmt) - 4'h1;
                  rx_st_r  <= ptp_pkg::S_BITS;
               end
            end
            ptp_pkg::S_BITS: begin
               if (rx_cnt_r != 16'h0) begin
                  rx_cnt_r <= rx_cnt_r - 16'h1;
               end else begin
                  rx_sh_r  <= {rxd, rx_sh_r[9:1]};
                  rx_cnt_r <= div_r - 16'h1;
                  rx_n_r   <= rx_n_r - 4'h1;
                  if (rx_n_r == 4'h1) rx_st_r <= ptp_pkg::S_END;
               end
            end
            ptp_pkg::S_END: begin
               rx_v_r    <= rx_ok;
               rx_byte_r <= rx_w[7:0];
               rx_st_r   <= ptp_pkg::S_IDLE;
            end
            default: rx_st_r <= ptp_pkg::S_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Request parser: control, command, checksum
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx_r    <= 2'h0;
         cmd_r    <= 8'h0;
         ex_v_r   <= 1'b0;
         ex_cmd_r <= 8'h0;
      end else begin
         ex_v_r <= 1'b0;
         if (rx_v_r) begin
            case (idx_r) // R1
               2'h0: if (rx_byte_r == `PTP_SYNC_BYTE) idx_r <= 2'h1; // R26
               2'h1: begin
                  cmd_r <= rx_byte_r;
                  idx_r <= 2'h2;
               end
               default: begin
                  idx_r <= 2'h0;
                  // Mismatch drops the request with no answer
                  if (rx_byte_r == (`PTP_SYNC_BYTE ^ cmd_r)) begin // R8 R9
                     ex_v_r   <= 1'b1;
                     ex_cmd_r <= cmd_r;
                  end
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Output cycle timer: free-running ms ticks, tick each cyc_r ms
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_cnt_r  <= 32'h0;
         cyc_cnt_r <= 5'h0;
         tick_r    <= 1'b0;
      end else begin
         tick_r <= 1'b0;
         if (ms_cnt_r >= MS_CYCLES - 1) begin
            ms_cnt_r <= 32'h0;
            if (cyc_cnt_r >= cyc_r - 5'h1) begin // R18
               cyc_cnt_r <= 5'h0;
               tick_r    <= 1'b1;
            end else begin
               cyc_cnt_r <= cyc_cnt_r + 5'h1;
            end
         end else begin
            ms_cnt_r <= ms_cnt_r + 32'h1;
         end
      end
   end

   // ==========================================================
   // Command execution; a new request wins over the launch clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         measure_r  <= 1'b0;
         sleep_r    <= 1'b0;
         per_r      <= 1'b0;
         per_kind_r <= ptp_pkg::K_POS;
         go_r       <= 1'b0;
         go_kind_r  <= ptp_pkg::K_POS;
      end else begin
         if (load) go_r <= 1'b0;
         if (tick_r && per_r) begin // R18
            go_r      <= 1'b1;
            go_kind_r <= per_kind_r;
         end
         if (ex_v_r) begin
            case (ex_cmd_r)
               `PTP_CMD_POS1, `PTP_CMD_POSC, `PTP_CMD_STOPC,
               `PTP_CMD_MON, `PTP_CMD_MOFF: begin // R3 R4
                  go_r      <= 1'b1;
                  go_kind_r <= ptp_pkg::K_POS;
               end
               `PTP_CMD_SPD1, `PTP_CMD_SPDC: begin // R5
                  go_r      <= 1'b1;
                  go_kind_r <= ptp_pkg::K_SPD;
               end
               `PTP_CMD_BOTH1, `PTP_CMD_BOTHC: begin // R6
                  go_r      <= 1'b1;
                  go_kind_r <= ptp_pkg::K_BOTH;
               end
               `PTP_CMD_MARK: begin // R7
                  go_r      <= 1'b1;
                  go_kind_r <= ptp_pkg::K_MARK;
               end
               `PTP_CMD_FAULT: begin // R7
                  go_r      <= 1'b1;
                  go_kind_r <= ptp_pkg::K_FLT;
               end
               default: ; // R25
            endcase
            case (ex_cmd_r)
               `PTP_CMD_POSC: begin // R3
                  per_r      <= 1'b1;
                  per_kind_r <= ptp_pkg::K_POS;
               end
               `PTP_CMD_SPDC: begin // R5
                  per_r      <= 1'b1;
                  per_kind_r <= ptp_pkg::K_SPD;
               end
               `PTP_CMD_BOTHC: begin // R6
                  per_r      <= 1'b1;
                  per_kind_r <= ptp_pkg::K_BOTH;
               end
               `PTP_CMD_STOPC: per_r <= 1'b0; // R3
               `PTP_CMD_MON: begin // R4
                  measure_r <= 1'b1;
                  sleep_r   <= 1'b0;
               end
               `PTP_CMD_MOFF: measure_r <= 1'b0; // R4
               `PTP_CMD_SLEEP: begin // R7
                  sleep_r   <= 1'b1;
                  measure_r <= 1'b0;
                  per_r     <= 1'b0;
               end
               default: ;
            endcase
         end
      end
   end

   // ==========================================================
   // Transmitter: snapshot telegram, shift bytes, append checksum
   logic [15:0] stat16;
   logic [47:0] pay48;
   logic [23:0] fcode;
   always_comb begin
      stat16 = {sense.tape_orientation_flag, sense.ready,
                sense.switch_line_two_state,
                sense.switch_line_one_state, 4'h0, // R13
                sense.temperature_warning_flag, sense.quality, // R24
                sleep_r, sense.marker_pending_flag,
                sense.diagnostic_pending_flag, sense.value_invalid,
                sense.device_error}; // R14
      case (sense.fault_sel) // R17
         3'h1, 3'h2, 3'h3, 3'h5:
            fcode = {`PTP_CHR_E, `PTP_CHR_0,
                     `PTP_CHR_0 | {5'h0, sense.fault_sel}};
         default: fcode = {`PTP_CHR_E, `PTP_CHR_0, `PTP_CHR_0};
      endcase
      case (go_kind_r)
         ptp_pkg::K_SPD:  pay48 = {16'h0, sense.speed, 16'h0}; // R15
         ptp_pkg::K_BOTH: pay48 = {sense.position, sense.speed}; // R23
         ptp_pkg::K_MARK: pay48 = {8'h00, sense.marker_label,
                                   16'h0}; // R12 R16
         ptp_pkg::K_FLT:  pay48 = {8'h00, fcode, 16'h0}; // R12
         default:         pay48 = {sense.position, 16'h0}; // R15
      endcase
      tx_byte = (left_r == 4'h1) ? chk_r : msg_r[71:64]; // R15
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st_r  <= ptp_pkg::S_IDLE;
         msg_r    <= 72'h0;
         left_r   <= 4'h0;
         chk_r    <= 8'h0;
         sh_r     <= 10'h3FF;
         bit_n_r  <= 4'h0;
         tx_cnt_r <= 16'h0;
         txd_r    <= 1'b1;
         rts_n_r  <= 1'b1;
      end else begin
         rts_n_r <= ~flow_eff; // R21
         case (tx_st_r)
            ptp_pkg::S_IDLE: if (load) begin
               msg_r   <= {stat16, pay48, 8'h0};
               chk_r   <= 8'h0;
               left_r  <= (go_kind_r == ptp_pkg::K_BOTH) ?
                          `PTP_LEN_LONG : `PTP_LEN_SHORT; // R10 R11
               tx_st_r <= ptp_pkg::S_START;
            end
            // Each byte waits for clear-to-send when flow is on
            ptp_pkg::S_START: if (!flow_eff || !cts_n) begin // R21
               sh_r     <= {1'b1, bit8(fmt, tx_byte), tx_byte}; // R19
               chk_r    <= chk_r ^ tx_byte; // R15
               msg_r    <= {msg_r[63:0], 8'h0};
               bit_n_r  <= nbits(fmt);
               tx_cnt_r <= div_r - 16'h1;
               txd_r    <= 1'b0;
               tx_st_r  <= ptp_pkg::S_BITS;
            end
            ptp_pkg::S_BITS: begin
               if (tx_cnt_r != 16'h0) begin
                  tx_cnt_r <= tx_cnt_r - 16'h1;
               end else if (bit_n_r == 4'h1) begin
                  tx_st_r <= ptp_pkg::S_END;
               end else begin
                  txd_r    <= sh_r[0];
                  sh_r     <= {1'b1, sh_r[9:1]};
                  bit_n_r  <= bit_n_r - 4'h1;
                  tx_cnt_r <= div_r - 16'h1;
               end
            end
            ptp_pkg::S_END: begin
               left_r  <= left_r - 4'h1;
               tx_st_r <= (left_r == 4'h1) ? ptp_pkg::S_IDLE :
                          ptp_pkg::S_START;
            end
            default: tx_st_r <= ptp_pkg::S_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Outputs, all flops
   assign prdata     = prdata_r;
   assign pready     = pready_r;
   assign pslverr    = pslverr_r;
   assign txd        = txd_r;
   assign rts_n      = rts_n_r;
   assign line_diff  = ctrl_r[`PTP_F_DIFF]; // R22
   assign measure_on = measure_r;
   assign sleep_on   = sleep_r;

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_sync_hunt: assert property ( // R26
      rx_v_r && idx_r == 2'h0 && rx_byte_r != `PTP_SYNC_BYTE
      |=> idx_r == 2'h0) else $error("Parser left hunt on bad byte");
   a_chk_drop: assert property ( // R9
      rx_v_r && idx_r == 2'h2 && rx_byte_r != (`PTP_SYNC_BYTE ^ cmd_r)
      |=> !ex_v_r ##1 !ex_v_r) else $error("Bad checksum executed");
   a_chk_exec: assert property ( // R8
      rx_v_r && idx_r == 2'h2 && rx_byte_r == (`PTP_SYNC_BYTE ^ cmd_r)
      |=> ex_v_r && ex_cmd_r == $past(cmd_r))
      else $error("Good request not executed");
   a_sleep_cmd: assert property ( // R7
      ex_v_r && ex_cmd_r == `PTP_CMD_SLEEP |=> sleep_r && !per_r)
      else $error("Sleep command not applied");
   a_measure_on: assert property ( // R4
      ex_v_r && ex_cmd_r == `PTP_CMD_MON |=> measure_r && !sleep_r)
      else $error("Measure start not applied");
   a_unknown_cmd: assert property ( // R25
      ex_v_r && ex_cmd_r == 8'hFB && !go_r && !(tick_r && per_r)
      |=> !go_r) else $error("Unknown command answered");
   a_len_nine: assert property ( // R11
      load && go_kind_r == ptp_pkg::K_BOTH |=> left_r == 4'h9)
      else $error("Combined reply not nine bytes");
   a_len_seven: assert property ( // R10
      load && go_kind_r != ptp_pkg::K_BOTH |=> left_r == 4'h7)
      else $error("Short reply not seven bytes");
   a_status_nib: assert property ( // R13
      load |=> msg_r[67:64] == 4'h0) else $error("Status nibble set");
   a_pad_zero: assert property ( // R12
      load && go_kind_r inside {ptp_pkg::K_MARK, ptp_pkg::K_FLT}
      |=> msg_r[55:48] == 8'h00) else $error("Pad byte not zero");
   a_cts_hold: assert property ( // R21
      tx_st_r == ptp_pkg::S_START && flow_eff && cts_n
      |=> txd_r && tx_st_r == ptp_pkg::S_START)
      else $error("Sent while clear-to-send off");

   c_single_pos: cover property (ex_v_r && ex_cmd_r == `PTP_CMD_POS1);
   c_periodic:   cover property (tick_r && per_r ##1 load);
   c_bad_chk:    cover property (rx_v_r && idx_r == 2'h2 &&
                    rx_byte_r != (`PTP_SYNC_BYTE ^ cmd_r));
endmodule

// ==== design/ptp_pkg.sv ====
// Purpose: Types shared by the telegram handler
// Assumes: Nothing
// Notes:   Gray codes along IDLE-START-BITS-END-IDLE; the transmitter END to START step flips two bits
package ptp_pkg;
   // ==========================================================
   // Serial engine states
   typedef enum logic [1:0] {
      S_IDLE  = 2'b00,
      S_START = 2'b01,
      S_BITS  = 2'b11,
      S_END   = 2'b10
   } ptp_ser_t;
   typedef enum logic [1:0] {
      F_8N1 = 2'b00,
      F_8E1 = 2'b01,
      F_8O1 = 2'b10,
      F_8N2 = 2'b11
   } ptp_fmt_t;
   typedef enum logic [2:0] {
      K_POS  = 3'h0,
      K_SPD  = 3'h1,
      K_BOTH = 3'h2,
      K_MARK = 3'h3,
      K_FLT  = 3'h4
   } ptp_kind_t;
   // Live sensor state sampled into each response
   typedef struct packed {
      logic        tape_orientation_flag;
      logic        ready;
      logic        switch_line_two_state;
      logic        switch_line_one_state;
      logic        temperature_warning_flag;
      logic [1:0]  quality;
      logic        marker_pending_flag;
      logic        diagnostic_pending_flag;
      logic        value_invalid;
      logic        device_error;
      logic [31:0] position;
      logic [15:0] speed;
      logic [23:0] marker_label;
      logic [2:0]  fault_sel;
   } ptp_sense_t;
endpackage
